// File: watchdog_timer_unit.sv
// Purpose: watchdog timer with timed-access control over apb
// Assumes: presetn is the power-on reset; power_fail is a one-cycle pulse
// Notes:   watchdog clock is pclk or the rc oscillator, chosen by a strap
//
// Overview of operation
// - bits 5:4 of watchdog_control choose the time-out interval
// - codes 0..3 give 2^17, 2^20, 2^23, 2^26 watchdog clocks
// - reaching the interval sets the time-out flag, bit 3
// - with bit 1 set, reset follows 512 clocks after unanswered time-out
// - watchdog reset lasts two machine cycles and sets cause flag bit 2
// - writing 1 to bit 0 zeroes the counter; bit then self-clears
// - interrupt needs time-out flag, enable bit 4 and global enable
// - time-out flag cleared by software write or by any reset
// - cause flag held until software, power-on or power-fail clears it
// - reset enable low stops only resets; counting and flags continue
// - power-on or power-fail disables; watchdog reset keeps it running
// - without interrupt or reset it is a free-running periodic timer
// - interval select resets to the shortest interval
// - protected bits accept writes only after the unlock sequence
// - run bit 7 lets the counter advance
// - strap bit picks rc oscillator or cpu clock for the counter
// - restart bit clears only once the counter is non-zero
// - wake from power-down only when clocked from the rc oscillator
`timescale 1ns/1ps
module watchdog_timer_unit
  import wdt_pkg::*;
#(
  parameter int unsigned TO_CLKS_0 = INT_CLKS_0,
  parameter int unsigned TO_CLKS_1 = INT_CLKS_1,
  parameter int unsigned TO_CLKS_2 = INT_CLKS_2,
  parameter int unsigned TO_CLKS_3 = INT_CLKS_3
)
(
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // register bus
  input  apb_req_t  apb_i,
  output apb_rsp_t  apb_o,
  // clock source and power
  input  wire logic rc_clk,
  input  wire logic clk_src_rc,
  input  wire logic power_fail,
  input  wire logic power_down,
  // outputs
  output logic      irq,
  output logic      sys_reset,
  output logic      wake
);

  typedef struct packed {
    logic             run;
    logic [1:0]       sel;
    logic             tof;
    logic             rcf;
    logic             rsten;
    logic             restart;
    logic             eie_wd;
    logic             gie;
    logic             src_rc;
    logic             src_cap;
    ta_state_t        ta;
    logic [CNT_W-1:0] cnt;
    logic             cleared;
    logic             waiting;
    logic [8:0]       post;
    logic [3:0]       rst_cnt;
    logic             sys_reset;
    logic             irq;
    logic             wake;
    apb_rsp_t         rsp;
  } wd_state_t;

  wd_state_t        s_r;
  wd_state_t        s_nxt;
  logic             rc_tick;
  logic             wd_tick;
  logic             access;
  logic             wr;
  logic             mapped;
  logic             unlocked;
  logic [CNT_W-1:0] limit;
  logic [31:0]      rd_val;

  rc_tick_sync u_rc_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .rc_clk  (rc_clk),
    .tick    (rc_tick)
  );

  assign wd_tick  = s_r.src_rc ? rc_tick : 1'b1;
  assign access   = apb_i.psel & apb_i.penable & ~s_r.rsp.pready;
  assign wr       = access & apb_i.pwrite;
  assign unlocked = (s_r.ta == TA_OPEN);
  assign mapped   = (apb_i.paddr == CTRL_OFS) | (apb_i.paddr == TA_OFS) |
                    (apb_i.paddr == EIE_OFS) | (apb_i.paddr == GIE_OFS) |
                    (apb_i.paddr == STAT_OFS);

  always_comb begin
    unique case (s_r.sel)
      2'h0: limit = CNT_W'(TO_CLKS_0 - 1);
      2'h1: limit = CNT_W'(TO_CLKS_1 - 1);
      2'h2: limit = CNT_W'(TO_CLKS_2 - 1);
      2'h3: limit = CNT_W'(TO_CLKS_3 - 1);
    endcase
  end

  always_comb begin
    rd_val = 32'h0000_0000;
    unique case (apb_i.paddr)
      CTRL_OFS: rd_val = {24'h000000, s_r.run, 1'b0, s_r.sel, s_r.tof,
                          s_r.rcf, s_r.rsten, s_r.restart};
      TA_OFS:   rd_val[UNLOCK_BIT] = unlocked;
      EIE_OFS:  rd_val[EIE_WD_BIT] = s_r.eie_wd;
      GIE_OFS:  rd_val[GIE_BIT] = s_r.gie;
      STAT_OFS: begin
        rd_val[SRC_BIT]     = s_r.src_rc;
        rd_val[CLEARED_BIT] = s_r.cleared;
        rd_val[WAITING_BIT] = s_r.waiting;
      end
      default:  rd_val = 32'h0000_0000;
    endcase
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.rsp.pready  = access;
    s_nxt.rsp.pslverr = access & ~mapped;
    s_nxt.rsp.prdata  = (access & ~apb_i.pwrite & mapped) ? rd_val : 32'h0000_0000;

    // strap caught once after reset release
    if (!s_r.src_cap) begin
      s_nxt.src_cap = 1'b1;
      s_nxt.src_rc  = clk_src_rc;
    end

    // unlock sequence, consumed by any other write
    if (wr && apb_i.paddr == TA_OFS) begin
      if (apb_i.pwdata[7:0] == TA_KEY1) begin
        s_nxt.ta = TA_KEY1_SEEN;
      end else if (s_r.ta == TA_KEY1_SEEN && apb_i.pwdata[7:0] == TA_KEY2) begin
        s_nxt.ta = TA_OPEN;
      end else begin
        s_nxt.ta = TA_LOCKED;
      end
    end else if (wr) begin
      s_nxt.ta = TA_LOCKED;
    end

    if (wr && apb_i.paddr == CTRL_OFS) begin
      if (unlocked) begin
        s_nxt.run   = apb_i.pwdata[RUN_BIT];
        s_nxt.sel   = apb_i.pwdata[SEL_HI_BIT:SEL_LO_BIT];
        s_nxt.rsten = apb_i.pwdata[RSTEN_BIT];
        s_nxt.tof   = apb_i.pwdata[TOF_BIT];
        if (apb_i.pwdata[RESTART_BIT]) begin
          s_nxt.restart = 1'b1;
          s_nxt.cleared = 1'b0;
        end
      end
      if (!apb_i.pwdata[RCF_BIT]) begin
        s_nxt.rcf = 1'b0;
      end
    end
    if (wr && apb_i.paddr == EIE_OFS) begin
      s_nxt.eie_wd = apb_i.pwdata[EIE_WD_BIT];
    end
    if (wr && apb_i.paddr == GIE_OFS) begin
      s_nxt.gie = apb_i.pwdata[GIE_BIT];
    end

    // completion seen back in the bus domain
    if (s_r.restart && s_r.cleared && s_r.cnt != '0) begin
      s_nxt.restart = 1'b0;
      s_nxt.cleared = 1'b0;
    end

    if (s_r.sys_reset) begin
      if (s_r.rst_cnt == 4'h0) begin
        s_nxt.sys_reset = 1'b0;
      end else begin
        s_nxt.rst_cnt = s_r.rst_cnt - 4'h1;
      end
    end else if (wd_tick) begin
      if (s_r.restart && !s_r.cleared) begin
        // request taken on a watchdog tick
        s_nxt.cnt     = '0;
        s_nxt.cleared = 1'b1;
        s_nxt.waiting = 1'b0;
        s_nxt.post    = 9'h000;
      end else if (s_r.run) begin
        s_nxt.cnt = s_r.cnt + CNT_W'(1);
        if (s_r.waiting) begin
          s_nxt.post = s_r.post + 9'h001;
          if (s_r.post == POST_LAST) begin
            s_nxt.waiting = 1'b0;
            s_nxt.post    = 9'h000;
            if (s_r.rsten) begin
              s_nxt.sys_reset = 1'b1;
              s_nxt.rst_cnt   = RST_HOLD_LAST;
              s_nxt.rcf       = 1'b1;
              s_nxt.tof       = 1'b0;
              s_nxt.cnt       = '0;
              s_nxt.restart   = 1'b0;
              s_nxt.cleared   = 1'b0;
              s_nxt.ta        = TA_LOCKED;
            end
          end
        end
        if (s_r.cnt >= limit && !s_nxt.sys_reset) begin
          s_nxt.cnt     = '0;
          s_nxt.tof     = 1'b1;
          s_nxt.waiting = 1'b1;
          s_nxt.post    = 9'h000;
        end
      end
    end

    if (power_fail) begin
      s_nxt.run     = 1'b0;
      s_nxt.rsten   = 1'b0;
      s_nxt.sel     = SEL_RESET;
      s_nxt.tof     = 1'b0;
      s_nxt.rcf     = 1'b0;
      s_nxt.restart = 1'b0;
      s_nxt.cleared = 1'b0;
      s_nxt.cnt     = '0;
      s_nxt.waiting = 1'b0;
      s_nxt.post    = 9'h000;
      s_nxt.ta      = TA_LOCKED;
    end

    s_nxt.irq  = s_nxt.tof & s_nxt.eie_wd & s_nxt.gie;
    s_nxt.wake = s_nxt.tof & s_nxt.src_rc & power_down;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r     <= '0;
      s_r.sel <= SEL_RESET;
      s_r.ta  <= TA_LOCKED;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign apb_o     = s_r.rsp;
  assign irq       = s_r.irq;
  assign sys_reset = s_r.sys_reset;
  assign wake      = s_r.wake;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_reset_pulse_width: assert property (
    $rose(s_r.sys_reset) |-> s_r.sys_reset [*8] ##1 !s_r.sys_reset)
    else $error("watchdog reset not held eight clocks");

  a_reset_sets_cause: assert property (
    $rose(s_r.sys_reset) |-> s_r.rcf && !s_r.tof && s_r.cnt == '0)
    else $error("watchdog reset without cause flag or restart");

  a_reset_after_grace: assert property (
    $rose(s_r.sys_reset) |-> $past(s_r.post) == POST_LAST && $past(s_r.waiting))
    else $error("watchdog reset not 512 clocks after time-out");

  a_reset_needs_enable: assert property (
    $rose(s_r.sys_reset) |-> $past(s_r.rsten) && $past(s_r.run))
    else $error("watchdog reset while reset function off");

  a_irq_gating: assert property (
    s_r.irq == (s_r.tof && s_r.eie_wd && s_r.gie))
    else $error("interrupt does not follow flag and enables");

  a_locked_write_ignored: assert property (
    wr && apb_i.paddr == CTRL_OFS && !unlocked && !power_fail && !s_r.sys_reset
    |=> $stable(s_r.run) && $stable(s_r.sel) && $stable(s_r.rsten))
    else $error("protected bits changed without unlock");

  a_waiting_has_flag: assert property (
    $rose(s_r.waiting) |-> s_r.tof && s_r.cnt == '0)
    else $error("time-out without flag");

  a_restart_holds: assert property (
    s_r.restart && s_r.cnt == '0 && !s_r.waiting && !power_fail |=> s_r.restart)
    else $error("restart bit cleared while counter zero");

  a_power_fail_off: assert property (
    power_fail |=> !s_r.run && !s_r.rcf && !s_r.tof && s_r.sel == SEL_RESET)
    else $error("power-fail did not disable watchdog");

  a_restart_zeroes: assert property (
    s_r.restart && !s_r.cleared && wd_tick && !s_r.sys_reset && !power_fail
    |=> s_r.cnt == '0 && s_r.cleared)
    else $error("restart did not zero counter");

endmodule

// File: wdt_pkg.sv
// Purpose: shared constants and carrier types for the watchdog timer unit
// Assumes: 32-bit apb, byte addresses, one clock pclk at 50 MHz
// Notes:   offsets are byte addresses of aligned words
package wdt_pkg;

  // register offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] TA_OFS   = 8'h04;
  localparam logic [7:0] EIE_OFS  = 8'h08;
  localparam logic [7:0] GIE_OFS  = 8'h0C;
  localparam logic [7:0] STAT_OFS = 8'h10;

  // watchdog_control field positions
  localparam int RUN_BIT     = 7;
  localparam int SEL_HI_BIT  = 5;
  localparam int SEL_LO_BIT  = 4;
  localparam int TOF_BIT     = 3;
  localparam int RCF_BIT     = 2;
  localparam int RSTEN_BIT   = 1;
  localparam int RESTART_BIT = 0;

  // other field positions
  localparam int EIE_WD_BIT  = 4;
  localparam int GIE_BIT     = 0;
  localparam int SRC_BIT     = 7;
  localparam int CLEARED_BIT = 1;
  localparam int WAITING_BIT = 0;
  localparam int UNLOCK_BIT  = 0;

  // reset values
  localparam logic [1:0] SEL_RESET   = 2'h0;
  localparam logic [7:0] CTRL_RESET  = 8'h00;

  // timed access keys
  localparam logic [7:0] TA_KEY1 = 8'hAA;
  localparam logic [7:0] TA_KEY2 = 8'h55;

  // timing counts
  localparam int          CNT_W         = 27;
  localparam int unsigned INT_CLKS_0    = 131072;
  localparam int unsigned INT_CLKS_1    = 1048576;
  localparam int unsigned INT_CLKS_2    = 8388608;
  localparam int unsigned INT_CLKS_3    = 67108864;
  localparam logic [8:0]  POST_LAST     = 9'h1FF;
  localparam int          CLKS_PER_MCYC = 4;
  localparam int          RST_MCYC      = 2;
  localparam logic [3:0]  RST_HOLD_LAST = 4'(CLKS_PER_MCYC * RST_MCYC - 1);

  typedef enum logic [1:0] {TA_LOCKED, TA_KEY1_SEEN, TA_OPEN} ta_state_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_t;

endpackage

// File: rc_tick_sync.sv
// Purpose: bring the rc oscillator into pclk and mark each rising edge
// Assumes: rc_clk well below half the pclk rate
// Notes:   tick is a one-cycle pulse, three pclk edges after the rc edge
`timescale 1ns/1ps
module rc_tick_sync
  import wdt_pkg::*;
(
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // oscillator in, tick out
  input  wire logic rc_clk,
  output logic      tick
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
    logic tick;
  } sync_state_t;

  sync_state_t s_r;
  sync_state_t s_nxt;

  always_comb begin
    s_nxt      = s_r;
    s_nxt.meta = rc_clk;
    s_nxt.sync = s_r.meta;
    s_nxt.prev = s_r.sync;
    s_nxt.tick = s_r.sync & ~s_r.prev;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tick = s_r.tick;

endmodule

// File: watchdog_timer_unit_tb.sv
// Purpose: self-checking bench for watchdog_timer_unit
// Assumes: intervals shortened to 16,32,64,1024; pclk source, then rc source
// Notes:   reads are checked from a queue by the response watcher
`timescale 1ns/1ps
module watchdog_timer_unit_tb;
  import wdt_pkg::*;
  localparam int unsigned TO [4] = '{16, 32, 64, 1024};
  logic        pclk;
  logic        presetn;
  apb_req_t    apb_i;
  apb_rsp_t    apb_o;
  logic        rc_clk, clk_src_rc, power_fail, power_down;
  logic        irq, sys_reset, wake, rst_prev;
  logic [1:0]  sel;
  logic [32:0] expq [$];
  int          errors, cmp_count, rst_rises, n, s0, r;

  watchdog_timer_unit #(.TO_CLKS_0(TO[0]), .TO_CLKS_1(TO[1]), .TO_CLKS_2(TO[2]),
    .TO_CLKS_3(TO[3])) DUT (.pclk(pclk), .presetn(presetn), .apb_i(apb_i), .apb_o(apb_o),
    .rc_clk(rc_clk), .clk_src_rc(clk_src_rc), .power_fail(power_fail),
    .power_down(power_down), .irq(irq), .sys_reset(sys_reset), .wake(wake));

  always #10 pclk = ~pclk;
  always #80 rc_clk = ~rc_clk;

  task check(input string what, input logic [32:0] seen, input logic [32:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    apb_i <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge pclk);
    apb_i.penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (apb_o.pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      check("pready", 1'b0, 1'b1);
      test_done();
    end
    apb_i.psel    <= 1'b0;
    apb_i.penable <= 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [32:0] e);
    expq.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask

  // unlock keys, then one control write
  task pw(input logic [7:0] d);
    apb(1'b1, TA_OFS, {24'h0, TA_KEY1});
    apb(1'b1, TA_OFS, {24'h0, TA_KEY2});
    apb(1'b1, CTRL_OFS, {24'h0, d});
  endtask

  function automatic logic sig(input int w);
    case (w)
      0: return irq;
      1: return sys_reset;
      default: return wake;
    endcase
  endfunction

  task wt(input int w, input logic lvl, input int lim, output int cnt);
    cnt = 0;
    do begin
      @(posedge pclk);
      cnt++;
    end while (sig(w) !== lvl && cnt < lim);
    if (sig(w) !== lvl) begin
      check("wait level", ~lvl, lvl);
      test_done();
    end
  endtask

  task do_reset(input logic src);
    presetn    <= 1'b0;
    clk_src_rc <= src;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  task test_end(input string nm);
    $display("test %s done", nm);
  endtask

  // response watcher: oldest note per read response
  always @(posedge pclk) begin
    rst_prev <= sys_reset;
    if (sys_reset === 1'b1 && rst_prev !== 1'b1) rst_rises++;
    if (apb_o.pready === 1'b1 && apb_i.pwrite === 1'b0) begin
      if (expq.size() == 0) check("spurious read", 1'b1, 1'b0);
      else check("read data", {apb_o.pslverr, apb_o.prdata}, expq.pop_front());
    end
  end

  initial begin
    pclk = 0; rc_clk = 0; presetn = 0; clk_src_rc = 0; power_fail = 0; power_down = 0;
    apb_i = '0; errors = 0; cmp_count = 0; rst_rises = 0; rst_prev = 0;
    s0 = $urandom(28936);
    do_reset(1'b0);
    rd(CTRL_OFS, 33'h0);
    rd(EIE_OFS, 33'h0);
    rd(GIE_OFS, 33'h0);
    rd(8'h14, 33'h1_0000_0000);
    test_end("reset values");
    apb(1'b1, CTRL_OFS, 32'h0000_00BB);
    rd(CTRL_OFS, 33'h0);
    apb(1'b1, TA_OFS, {24'h0, TA_KEY1});
    apb(1'b1, TA_OFS, {24'h0, TA_KEY2});
    rd(TA_OFS, 33'h1);
    apb(1'b1, CTRL_OFS, 32'h0000_0001);
    rd(CTRL_OFS, 33'h1);
    apb(1'b1, CTRL_OFS, 32'h0000_0080);
    rd(CTRL_OFS, 33'h1);
    test_end("timed access");
    apb(1'b1, EIE_OFS, 32'h0000_0010);
    apb(1'b1, GIE_OFS, 32'h0000_0001);
    power_down <= 1'b1;
    s0 = $urandom % 4;
    for (int i = 0; i < 4; i++) begin
      sel = 2'((s0 + i) % 4);
      pw({2'b10, sel, 4'h1});
      wt(0, 1'b1, 1100, n);
      check("interval", n >= TO[sel] - 3 && n <= TO[sel] + 3, 1'b1);
      check("wake on pclk", wake, 1'b0);
      rd(CTRL_OFS, {25'h0, 2'b10, sel, 4'h8});
      repeat (2) @(posedge pclk);
    end
    pw(8'h80);
    wt(0, 1'b1, 40, n);
    check("periodic", n <= 18, 1'b1);
    pw(8'hB8);
    repeat (1600) @(posedge pclk);
    check("no reset", rst_rises, 33'h0);
    apb(1'b1, GIE_OFS, 32'h0);
    @(posedge pclk);
    check("irq gie off", irq, 1'b0);
    apb(1'b1, GIE_OFS, 32'h1);
    apb(1'b1, EIE_OFS, 32'h0);
    @(posedge pclk);
    check("irq eie off", irq, 1'b0);
    apb(1'b1, EIE_OFS, 32'h0000_0010);
    @(posedge pclk);
    check("irq on", irq, 1'b1);
    pw(8'hB0);
    rd(CTRL_OFS, 33'h0_0000_00B0);
    test_end("intervals and interrupt");
    pw(8'hB3);
    wt(0, 1'b1, 1100, n);
    wt(1, 1'b1, 600, n);
    check("grace", n >= 509 && n <= 515, 1'b1);
    wt(1, 1'b0, 20, n);
    check("reset length", n, 33'h8);
    rd(CTRL_OFS, 33'h0_0000_00B6);
    wt(0, 1'b1, 1100, n);
    check("restarted", n >= 1015 && n <= 1025, 1'b1);
    apb(1'b1, CTRL_OFS, 32'h0);
    rd(CTRL_OFS, 33'h0_0000_00BA);
    repeat (100) @(posedge pclk);
    pw(8'hB3);
    r = rst_rises;
    repeat (600) @(posedge pclk);
    check("restart in grace", rst_rises, r);
    power_fail <= 1'b1;
    @(posedge pclk);
    power_fail <= 1'b0;
    rd(CTRL_OFS, 33'h0);
    check("irq after fail", irq, 1'b0);
    test_end("watchdog reset");
    power_down <= 1'b0;
    do_reset(1'b1);
    apb(1'b1, EIE_OFS, 32'h0000_0010);
    apb(1'b1, GIE_OFS, 32'h0000_0001);
    pw(8'h81);
    repeat (24) @(posedge pclk);
    rd(CTRL_OFS, 33'h0_0000_0080);
    power_down <= 1'b1;
    wt(2, 1'b1, 400, n);
    check("rc interval", n >= 90 && n <= 114, 1'b1);
    check("irq rc", irq, 1'b1);
    power_down <= 1'b0;
    repeat (2) @(posedge pclk);
    check("wake off", wake, 1'b0);
    test_end("rc source");
    @(posedge pclk);
    check("queue drained", expq.size(), 33'h0);
    test_done();
  end
endmodule
